// ==== design/bpb_params.svh ====
// constants for the bus port of the host bridge
// How it works
// - interrupt inputs are level, low, pending while low
// - agent holds interrupt until software clears it
// - each master drives low request to arbiter
// - arbiter drives a separate low grant each
// - bridge drives low bus reset to agents
// - bridge divides and drives the bus clock
// - system error is a synchronous input
// - data receiver flags parity error two clocks later
// - parity error line is sustained, one clock minimum
// - only master or claiming target report parity
// - address phase is the single frame clock
// - byte 0 on bits 7:0, byte 3 on 31:24
// - data moves only when both ready lines low
// - data valid whenever writer asserts its ready
// - target stop makes the master end transfer
// - target claims with device select, master samples it
// - command in address phase, byte enables after
// - byte enables valid for the whole data phase
// - master raises frame for final data phase
// - even parity, one clock after its data
// - master drives parity on address/write, target on read
// - strap high at reset enables four masters
`ifndef BPB_PARAMS_SVH
`define BPB_PARAMS_SVH
`define BPB_CLK_PERIOD_NS 4
`define BPB_BUS_PERIOD_NS 40
`define BPB_BUS_HALF      (`BPB_BUS_PERIOD_NS / (2 * `BPB_CLK_PERIOD_NS))
`define BPB_RST_HOLD      5'h10
`define BPB_DEVSEL_TMO    3'h4
`define BPB_CMD_READ      4'h6
`define BPB_CMD_WRITE     4'h7
`define BPB_AGENT_BASE    28'h0001000
`endif

// ==== design/bpb_pkg.sv ====
// types and parity function shared by both ends
`default_nettype none
package bpb_pkg;
   typedef enum logic [2:0] {
      M_IDLE = 3'h0, M_ADDR = 3'h1, M_DATA = 3'h3, M_TURN = 3'h2, M_PERR = 3'h6
   } bpb_mst_e;
   typedef enum logic [1:0] {
      A_IDLE = 2'h0, A_DATA = 2'h1, A_TURN = 2'h3, A_PERR = 2'h2
   } bpb_tgt_e;
   typedef struct packed {
      logic [3:0]  int_n;
      logic [3:0]  req_n;
      logic        serr_n;
      logic        perr_n;
      logic        frame_n;
      logic        irdy_n;
      logic        trdy_n;
      logic        stop_n;
      logic        devsel_n;
      logic        par;
      logic        strap;
      logic [3:0]  cbe_n;
      logic [31:0] ad;
   } bpb_pins_s;
   // even parity bit over address/data and command/enables
   function automatic logic parity(input logic [31:0] ad, input logic [3:0] cbe);
      parity = ^{ad, cbe};
   endfunction
endpackage
`default_nettype wire

// ==== design/bpb_bus_if.sv ====
// shared bus between the bridge and one agent, with pull-ups
`timescale 1ns/1ps
`default_nettype none
interface bpb_bus_if;
   logic        bus_clk, bus_rst_n;
   logic [3:0]  gnt_n;
   logic [3:1]  extra_req_n, extra_int_n;   // driven by the bench
   logic        agent_req_n, agent_int_n, serr_n;
   logic [3:0]  req_n, int_n;
   logic        br_frame_n, br_frame_oe, br_irdy_n, br_irdy_oe;
   logic [31:0] br_ad, ag_ad, ad;
   logic        br_ad_oe, ag_ad_oe;
   logic [3:0]  br_cbe_n, cbe_n;
   logic        br_cbe_oe;
   logic        br_par, br_par_oe, ag_par, ag_par_oe, par;
   logic        br_perr_n, br_perr_oe, ag_perr_n, ag_perr_oe, perr_n;
   logic        ag_trdy_n, ag_stop_n, ag_devsel_n, ag_tgt_oe;
   logic        frame_n, irdy_n, trdy_n, stop_n, devsel_n;
   // wire levels worked out from the enables; undriven lines float high
   assign req_n    = {extra_req_n, agent_req_n};
   assign int_n    = {extra_int_n, agent_int_n};
   assign frame_n  = br_frame_oe ? br_frame_n : 1'b1;
   assign irdy_n   = br_irdy_oe ? br_irdy_n : 1'b1;
   assign cbe_n    = br_cbe_oe ? br_cbe_n : 4'hF;
   assign ad       = br_ad_oe ? br_ad : (ag_ad_oe ? ag_ad : 32'hFFFFFFFF);
   assign par      = br_par_oe ? br_par : (ag_par_oe ? ag_par : 1'b1);
   assign perr_n   = (br_perr_oe ? br_perr_n : 1'b1) & (ag_perr_oe ? ag_perr_n : 1'b1);
   assign trdy_n   = ag_tgt_oe ? ag_trdy_n : 1'b1;
   assign stop_n   = ag_tgt_oe ? ag_stop_n : 1'b1;
   assign devsel_n = ag_tgt_oe ? ag_devsel_n : 1'b1;
   modport bridge (
      output bus_clk, bus_rst_n, gnt_n, br_frame_n, br_frame_oe, br_irdy_n, br_irdy_oe,
             br_ad, br_ad_oe, br_cbe_n, br_cbe_oe, br_par, br_par_oe, br_perr_n, br_perr_oe,
      input  req_n, int_n, serr_n, perr_n, frame_n, irdy_n, trdy_n, stop_n, devsel_n,
             ad, cbe_n, par
   );
   modport agent (
      output agent_req_n, agent_int_n, ag_ad, ag_ad_oe, ag_par, ag_par_oe, ag_perr_n,
             ag_perr_oe, ag_trdy_n, ag_stop_n, ag_devsel_n, ag_tgt_oe,
      input  bus_clk, bus_rst_n, gnt_n, frame_n, irdy_n, ad, cbe_n, par
   );
endinterface
`default_nettype wire

// ==== design/bpb_rr_arbiter.sv ====
// rotating-priority pick among active-high requests
`timescale 1ns/1ps
`default_nettype none
module bpb_rr_arbiter (
   input  wire  logic       clk_i,
   input  wire  logic       reset_i,
   input  wire  logic [3:0] req_i,
   input  wire  logic       advance_i,
   output logic       [3:0] pick_o
);
   typedef struct packed {
      logic [1:0] ptr;
   } bpb_arb_s;
   bpb_arb_s q, d;
   // search starts one past the last winner, so none starves
   always_comb begin
      logic       found;
      logic [1:0] idx;
      logic [1:0] win;
      found = 1'b0;
      idx = 2'h0;
      win = q.ptr;
      pick_o = 4'h0;
      d = q;
      for (int k = 1; k <= 4; k++) begin
         idx = 2'(q.ptr + 2'(k));
         if (!found && req_i[idx]) begin
            pick_o[idx] = 1'b1;
            found = 1'b1;
            win = idx;
         end
      end
      if (advance_i) begin
         d.ptr = win;
      end
      if (reset_i) begin
         d.ptr = 2'h3;
      end
   end
   always_ff @(posedge clk_i) begin
      q <= d;
   end
endmodule
`default_nettype wire

// ==== design/bpb_bridge.sv ====
// bridge end: bus clock, bus reset, arbiter, interrupts, single-phase master
`timescale 1ns/1ps
`default_nettype none
`include "bpb_params.svh"
module bpb_bridge (
   input  wire  logic        CLK_I,
   input  wire  logic        RESET_I,
   input  wire  logic        STRAP_EXT_ARB_I,
   input  wire  logic        REQ_VALID_I,
   input  wire  logic        REQ_WRITE_I,
   input  wire  logic [31:0] REQ_ADDR_I,
   input  wire  logic [31:0] REQ_DATA_I,
   input  wire  logic [3:0]  REQ_BE_N_I,
   output logic              REQ_READY_O,
   output logic              RSP_VALID_O,
   output logic       [31:0] RSP_DATA_O,
   output logic       [1:0]  RSP_STATUS_O,
   output logic       [3:0]  INT_PENDING_O,
   output logic              SYSTEM_ERROR_O,
   output logic              PARITY_ERROR_O,
   bpb_bus_if.bridge         bus
);
   localparam logic [2:0] HALF_LAST = 3'(`BPB_BUS_HALF - 1);
   typedef struct packed {
      bpb_pkg::bpb_pins_s s1, s2;
      bpb_pkg::bpb_pins_s seen;
      logic [2:0]  div;
      logic        clk, rst_n, ext4;
      logic [4:0]  rst_cnt;
      logic [3:0]  gnt_n;
      bpb_pkg::bpb_mst_e mst;
      logic        pend, wr;
      logic [31:0] addr, wdata, rdata;
      logic [3:0]  be_n, rcbe_n;
      logic [2:0]  tmo;
      logic [1:0]  status;
      logic        frame_n, irdy_n, mst_oe, ad_oe, par, par_oe, perr_n, perr_oe;
      logic [31:0] ad;
      logic [3:0]  cbe_n;
      logic        ready, rsp_valid;
      logic [3:0]  int_pend;
      logic        serr, perr_seen;
   } bpb_br_s;
   bpb_br_s q, d;
   logic [3:0] pick;
   logic       advance;
   logic       fall;
   bpb_pkg::bpb_pins_s pins;
   // pin levels gathered for the two-flop synchroniser
   assign pins = {bus.int_n, bus.req_n, bus.serr_n, bus.perr_n, bus.frame_n, bus.irdy_n,
                  bus.trdy_n, bus.stop_n, bus.devsel_n, bus.par, STRAP_EXT_ARB_I, bus.cbe_n,
                  bus.ad};
   bpb_rr_arbiter u_arb (
      .clk_i     (CLK_I),
      .reset_i   (RESET_I),
      .req_i     (~q.s2.req_n & (q.ext4 ? 4'hF : 4'h3)),
      .advance_i (advance),
      .pick_o    (pick)
   );
   // all the bridge's next-state logic
   always_comb begin
      d = q;
      advance = 1'b0;
      // pins pass two flops before use
      d.s1 = pins;
      d.s2 = q.s1;
      // bus as agents sample it at the rising edge; the target lets go by the fall
      if (q.div == HALF_LAST && !q.clk) begin
         d.seen = q.s2;
      end
      d.rsp_valid = 1'b0;
      d.int_pend = ~q.s2.int_n;
      d.serr = ~q.s2.serr_n;
      d.perr_seen = ~q.s2.perr_n;
      // request port takes one command at a time
      d.ready = q.rst_n && !q.pend && !(REQ_VALID_I && q.ready);
      if (REQ_VALID_I && q.ready) begin
         d.pend = 1'b1;
         d.wr = REQ_WRITE_I;
         d.addr = REQ_ADDR_I;
         d.wdata = REQ_DATA_I;
         d.be_n = REQ_BE_N_I;
      end
      fall = (q.div == HALF_LAST) && q.clk;
      if (q.div == HALF_LAST) begin
         d.div = 3'h0;
         d.clk = ~q.clk;
      end else begin
         d.div = q.div + 3'h1;
      end
      // bridge outputs change on the falling bus edge, agents sample on rising
      if (fall && !q.rst_n) begin
         if (q.rst_cnt == `BPB_RST_HOLD) begin
            d.rst_n = 1'b1;
            d.ext4 = q.s2.strap;
         end else begin
            d.rst_cnt = q.rst_cnt + 5'h1;
         end
      end else if (fall) begin
         // grant only on an idle bus
         if (q.mst == bpb_pkg::M_IDLE && q.s2.frame_n && q.s2.irdy_n) begin
            d.gnt_n = ~pick;
            advance = |pick;
         end
         unique case (q.mst)
            bpb_pkg::M_IDLE: begin
               d.mst_oe = 1'b0;
               d.perr_oe = 1'b0;
               if (q.pend && pick == 4'h0 && &q.gnt_n && q.s2.frame_n && q.s2.irdy_n) begin
                  d.frame_n = 1'b0;
                  d.ad = q.addr;
                  d.ad_oe = 1'b1;
                  d.mst_oe = 1'b1;
                  d.cbe_n = q.wr ? `BPB_CMD_WRITE : `BPB_CMD_READ;
                  d.status = 2'h0;
                  d.tmo = 3'h0;
                  d.mst = bpb_pkg::M_ADDR;
               end
            end
            bpb_pkg::M_ADDR: begin
               // single data phase, frame raised now
               d.frame_n = 1'b1;
               d.irdy_n = 1'b0;
               // byte enables for the data phase
               d.cbe_n = q.be_n;
               d.ad = q.wdata;
               d.ad_oe = q.wr;
               d.par = bpb_pkg::parity(q.ad, q.cbe_n);
               d.par_oe = 1'b1;
               d.mst = bpb_pkg::M_DATA;
            end
            bpb_pkg::M_DATA: begin
               d.par = bpb_pkg::parity(q.wdata, q.be_n);
               d.par_oe = q.wr;
               // transfer on both ready at the last rising edge
               if (!q.seen.trdy_n) begin
                  d.rdata = q.seen.ad;
                  d.rcbe_n = q.seen.cbe_n;
                  d.mst = bpb_pkg::M_TURN;
               end else if (!q.seen.stop_n) begin
                  d.status = 2'h1;
                  d.mst = bpb_pkg::M_TURN;
               end else if (q.seen.devsel_n && q.tmo == `BPB_DEVSEL_TMO) begin
                  d.status = 2'h2;
                  d.mst = bpb_pkg::M_TURN;
               end else begin
                  d.tmo = q.tmo + 3'h1;
               end
               if (d.mst == bpb_pkg::M_TURN) begin
                  d.irdy_n = 1'b1;
                  d.ad_oe = 1'b0;
               end
            end
            bpb_pkg::M_TURN: begin
               d.par_oe = 1'b0;
               d.pend = 1'b0;
               d.rsp_valid = 1'b1;
               d.mst = bpb_pkg::M_IDLE;
               // read parity checked, error two clocks after data
               if (!q.wr && q.status == 2'h0 &&
                   q.seen.par != bpb_pkg::parity(q.rdata, q.rcbe_n)) begin
                  // reported as master of this transfer
                  d.perr_n = 1'b0;
                  d.perr_oe = 1'b1;
                  d.status = 2'h3;
                  d.mst = bpb_pkg::M_PERR;
               end
            end
            bpb_pkg::M_PERR: begin
               // held one clock, then driven high before release
               d.perr_n = 1'b1;
               d.mst = bpb_pkg::M_IDLE;
            end
            default: begin
               d.mst = bpb_pkg::M_IDLE;
            end
         endcase
      end
      if (RESET_I) begin
         d = '0;
         // synchroniser keeps sampling so release finds it flushed
         d.s1 = pins;
         d.s2 = q.s1;
         d.gnt_n = 4'hF;
         d.frame_n = 1'b1;
         d.irdy_n = 1'b1;
         d.perr_n = 1'b1;
         d.cbe_n = 4'hF;
      end
   end
   always_ff @(posedge CLK_I) begin
      q <= d;
   end
   // pins and user outputs straight from flops
   assign bus.bus_clk = q.clk;
   assign bus.bus_rst_n = q.rst_n;
   assign bus.gnt_n = q.gnt_n;
   assign bus.br_frame_n = q.frame_n;
   assign bus.br_frame_oe = q.mst_oe;
   assign bus.br_irdy_n = q.irdy_n;
   assign bus.br_irdy_oe = q.mst_oe;
   assign bus.br_ad = q.ad;
   assign bus.br_ad_oe = q.ad_oe;
   assign bus.br_cbe_n = q.cbe_n;
   assign bus.br_cbe_oe = q.mst_oe;
   assign bus.br_par = q.par;
   assign bus.br_par_oe = q.par_oe;
   assign bus.br_perr_n = q.perr_n;
   assign bus.br_perr_oe = q.perr_oe;
   assign REQ_READY_O = q.ready;
   assign RSP_VALID_O = q.rsp_valid;
   assign RSP_DATA_O = q.rdata;
   assign RSP_STATUS_O = q.status;
   assign INT_PENDING_O = q.int_pend;
   assign SYSTEM_ERROR_O = q.serr;
   assign PARITY_ERROR_O = q.perr_seen;
endmodule
`default_nettype wire

// ==== design/bpb_agent.sv ====
// agent end: requester, interrupt source and four-word target on the bus clock
`timescale 1ns/1ps
`default_nettype none
`include "bpb_params.svh"
module bpb_agent (
   input  wire  logic        REQUEST_I,
   input  wire  logic        INT_REQ_I,
   input  wire  logic        RETRY_I,
   output logic              GRANTED_O,
   output logic              WRITE_STROBE_O,
   output logic       [1:0]  WRITE_INDEX_O,
   output logic       [31:0] WRITE_DATA_O,
   output logic              PARITY_FAULT_O,
   bpb_bus_if.agent          bus
);
   typedef struct packed {
      logic [3:0][31:0] mem;
      bpb_pkg::bpb_tgt_e st;
      logic        wr, retry;
      logic [1:0]  idx;
      logic [31:0] dat;
      logic [3:0]  be_n;
      logic        req_n, int_n, granted;
      logic        trdy_n, stop_n, devsel_n, tgt_oe;
      logic [31:0] ad;
      logic        ad_oe, par, par_oe, perr_n, perr_oe;
      logic        wstb, pfault;
      logic [2:0]  sy1, sy2;
   } bpb_ag_s;
   bpb_ag_s q, d;
   always_comb begin
      d = q;
      d.wstb = 1'b0;
      // user inputs come from another clock: two flops first
      d.sy1 = {RETRY_I, INT_REQ_I, REQUEST_I};
      d.sy2 = q.sy1;
      // request line, interrupt held by user
      d.req_n = ~q.sy2[0];
      d.int_n = ~q.sy2[1];
      d.granted = ~bus.gnt_n[0];
      unique case (q.st)
         bpb_pkg::A_IDLE: begin
            d.tgt_oe = 1'b0;
            d.ad_oe = 1'b0;
            d.par_oe = 1'b0;
            d.perr_oe = 1'b0;
            if (!bus.frame_n && bus.ad[31:4] == `BPB_AGENT_BASE &&
                (bus.cbe_n == `BPB_CMD_READ || bus.cbe_n == `BPB_CMD_WRITE)) begin
               d.wr = (bus.cbe_n == `BPB_CMD_WRITE);
               d.idx = bus.ad[3:2];
               d.retry = q.sy2[2];
               d.devsel_n = 1'b0;
               d.tgt_oe = 1'b1;
               // retry asks the master to stop
               d.stop_n = ~q.sy2[2];
               d.trdy_n = q.sy2[2];
               d.ad = q.mem[bus.ad[3:2]];
               d.ad_oe = (bus.cbe_n == `BPB_CMD_READ) && !q.sy2[2];
               d.st = bpb_pkg::A_DATA;
            end
         end
         bpb_pkg::A_DATA: begin
            if (!bus.irdy_n || q.retry) begin
               if (!q.retry) begin
                  d.dat = q.wr ? bus.ad : q.ad;
                  d.be_n = bus.cbe_n;
                  if (q.wr) begin
                     for (int b = 0; b < 4; b++) begin
                        if (!bus.cbe_n[b]) begin
                           d.mem[q.idx][8*b +: 8] = bus.ad[8*b +: 8];
                        end
                     end
                     d.wstb = 1'b1;
                  end
                  d.par = bpb_pkg::parity(q.ad, bus.cbe_n);
                  d.par_oe = !q.wr;
               end
               d.trdy_n = 1'b1;
               d.stop_n = 1'b1;
               d.devsel_n = 1'b1;
               d.ad_oe = 1'b0;
               d.st = bpb_pkg::A_TURN;
            end
         end
         bpb_pkg::A_TURN: begin
            d.tgt_oe = 1'b0;
            d.par_oe = 1'b0;
            d.st = bpb_pkg::A_IDLE;
            // write parity checked one clock after data
            if (q.wr && !q.retry && bus.par != bpb_pkg::parity(q.dat, q.be_n)) begin
               d.perr_n = 1'b0;
               d.perr_oe = 1'b1;
               d.pfault = 1'b1;
               d.st = bpb_pkg::A_PERR;
            end
         end
         bpb_pkg::A_PERR: begin
            // one low clock, then driven high
            d.perr_n = 1'b1;
            d.pfault = 1'b0;
            d.st = bpb_pkg::A_IDLE;
         end
      endcase
      // bus reset brings agent to a known state
      if (!bus.bus_rst_n) begin
         d = '0;
         d.mem = q.mem;
         d.req_n = 1'b1;
         d.int_n = 1'b1;
         d.trdy_n = 1'b1;
         d.stop_n = 1'b1;
         d.devsel_n = 1'b1;
         d.perr_n = 1'b1;
      end
   end
   always_ff @(posedge bus.bus_clk) begin
      q <= d;
   end
   assign bus.agent_req_n = q.req_n;
   assign bus.agent_int_n = q.int_n;
   assign bus.ag_ad = q.ad;
   assign bus.ag_ad_oe = q.ad_oe;
   assign bus.ag_par = q.par;
   assign bus.ag_par_oe = q.par_oe;
   assign bus.ag_perr_n = q.perr_n;
   assign bus.ag_perr_oe = q.perr_oe;
   assign bus.ag_trdy_n = q.trdy_n;
   assign bus.ag_stop_n = q.stop_n;
   assign bus.ag_devsel_n = q.devsel_n;
   assign bus.ag_tgt_oe = q.tgt_oe;
   assign GRANTED_O = q.granted;
   assign WRITE_STROBE_O = q.wstb;
   assign WRITE_INDEX_O = q.idx;
   assign WRITE_DATA_O = q.dat;
   assign PARITY_FAULT_O = q.pfault;
endmodule
`default_nettype wire

// ==== design/bpb_dummy_never.sv ====
`timescale 1ns/1ps

// ==== tb/bpb_bus_checker.sv ====
// concurrent checks on the shared bus between bridge and agent
`timescale 1ns/1ps
`default_nettype none
module bpb_bus_checker (
   input wire logic        bus_clk,
   input wire logic        bus_rst_n,
   input wire logic [3:0]  gnt_n,
   input wire logic        frame_n,
   input wire logic        irdy_n,
   input wire logic        trdy_n,
   input wire logic        stop_n,
   input wire logic        devsel_n,
   input wire logic [31:0] ad,
   input wire logic [3:0]  cbe_n,
   input wire logic        par,
   input wire logic        br_ad_oe,
   input wire logic        ag_ad_oe,
   input wire logic        br_par_oe,
   input wire logic        ag_par_oe
);
   default clocking cb @(posedge bus_clk); endclocking
   default disable iff (!bus_rst_n);
   // a data phase completes on this sample
   wire logic dx = !irdy_n && !trdy_n;
   property p_one_gnt; $onehot0(~gnt_n); endproperty
   property p_addr; $fell(frame_n) |=> frame_n && !irdy_n; endproperty
   property p_cmd; $fell(frame_n) |-> cbe_n inside {4'h6, 4'h7}; endproperty
   property p_apar; $fell(frame_n) |=> par == ^{$past(ad), $past(cbe_n)}; endproperty
   property p_xfer; dx |=> irdy_n && trdy_n; endproperty
   property p_dpar; dx |=> par == ^{$past(ad), $past(cbe_n)}; endproperty
   property p_pown; dx && ag_ad_oe |=> ag_par_oe && !br_par_oe; endproperty
   property p_data; dx |-> br_ad_oe ^ ag_ad_oe; endproperty
   property p_claim; $fell(frame_n) && ad[31:4] == 28'h0001000 |=> !devsel_n; endproperty
   property p_stop; !stop_n |-> ##[1:2] irdy_n; endproperty
   a_one_gnt: assert property (p_one_gnt) else $error("two grants low");
   a_addr: assert property (p_addr) else $error("address phase not one clock");
   a_cmd: assert property (p_cmd) else $error("bad command");
   a_apar: assert property (p_apar) else $error("address parity");
   a_xfer: assert property (p_xfer) else $error("ready held after transfer");
   a_dpar: assert property (p_dpar) else $error("data parity");
   a_pown: assert property (p_pown) else $error("read parity owner");
   a_data: assert property (p_data) else $error("data driver");
   a_claim: assert property (p_claim) else $error("no device select");
   a_stop: assert property (p_stop) else $error("stop ignored");
   c_read: cover property (dx && ag_ad_oe);
   c_write: cover property (dx && br_ad_oe);
   c_retry: cover property (!stop_n);
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench: bridge and agent joined over the shared bus
`timescale 1ns/1ps
`default_nettype none
module tb;
   typedef struct packed {
      logic        wr;
      logic        retry;
      logic [1:0]  st;
      logic [31:0] addr;
      logic [31:0] data;
   } bpb_row_s;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        strap = 1'b0;
   logic        rq_valid = 1'b0;
   logic        rq_wr = 1'b0;
   logic [31:0] rq_addr = 32'h0;
   logic [31:0] rq_data = 32'h0;
   logic        ag_req = 1'b0;
   logic        ag_int = 1'b0;
   logic        ag_retry = 1'b0;
   logic        rq_ready, rsp_valid, sys_err, granted;
   logic [31:0] rsp_data, wr_data;
   logic [1:0]  rsp_st, wr_idx;
   logic [3:0]  int_pend, pat;
   logic [3:0]  rq_be = 4'h0;
   logic        wr_stb, par_err, pfault;
   int          n_wstb = 0;
   int          n_perr = 0;
   int          n_errors = 0;
   int          tests_run = 0;
   int          n;
   time         t0;
   // ordinary transfers: write, read back, abort, retry
   bpb_row_s rows [7] = '{
      '{1'b1, 1'b0, 2'h0, 32'h0001_0000, 32'hA5A5_0001},
      '{1'b1, 1'b0, 2'h0, 32'h0001_000C, 32'h8000_00FF},
      '{1'b0, 1'b0, 2'h0, 32'h0001_000C, 32'h8000_00FF},
      '{1'b0, 1'b0, 2'h0, 32'h0001_0000, 32'hA5A5_0001},
      '{1'b0, 1'b0, 2'h2, 32'h0002_0000, 32'h0},
      '{1'b1, 1'b1, 2'h1, 32'h0001_0004, 32'h0},
      '{1'b0, 1'b1, 2'h1, 32'h0001_0004, 32'h0}
   };
   always #2 clk = ~clk;
   bpb_bus_if bus_if ();
   bpb_bridge u_bpb_bridge (.CLK_I(clk), .RESET_I(rst), .STRAP_EXT_ARB_I(strap),
      .REQ_VALID_I(rq_valid), .REQ_WRITE_I(rq_wr), .REQ_ADDR_I(rq_addr),
      .REQ_DATA_I(rq_data), .REQ_BE_N_I(rq_be), .REQ_READY_O(rq_ready),
      .RSP_VALID_O(rsp_valid), .RSP_DATA_O(rsp_data), .RSP_STATUS_O(rsp_st),
      .INT_PENDING_O(int_pend), .SYSTEM_ERROR_O(sys_err), .PARITY_ERROR_O(par_err),
      .bus(bus_if));
   bpb_agent u_bpb_agent (.REQUEST_I(ag_req), .INT_REQ_I(ag_int), .RETRY_I(ag_retry),
      .GRANTED_O(granted), .WRITE_STROBE_O(wr_stb), .WRITE_INDEX_O(wr_idx),
      .WRITE_DATA_O(wr_data), .PARITY_FAULT_O(pfault), .bus(bus_if));
   bpb_bus_checker u_bpb_bus_checker (.bus_clk(bus_if.bus_clk),
      .bus_rst_n(bus_if.bus_rst_n), .gnt_n(bus_if.gnt_n), .frame_n(bus_if.frame_n),
      .irdy_n(bus_if.irdy_n), .trdy_n(bus_if.trdy_n), .stop_n(bus_if.stop_n),
      .devsel_n(bus_if.devsel_n), .ad(bus_if.ad), .cbe_n(bus_if.cbe_n), .par(bus_if.par),
      .br_ad_oe(bus_if.br_ad_oe), .ag_ad_oe(bus_if.ag_ad_oe),
      .br_par_oe(bus_if.br_par_oe), .ag_par_oe(bus_if.ag_par_oe));
   // strobes and parity flags counted in the middle of a bus clock
   always @(negedge bus_if.bus_clk) begin
      if (wr_stb === 1'b1)
         n_wstb++;
      if (par_err === 1'b1 || pfault === 1'b1)
         n_perr++;
   end
   // value compare with counting
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // one command through the request port, waits for its response
   task automatic txn(input bpb_row_s r);
      @(negedge clk);
      ag_retry = r.retry;
      // retry must pass the agent's synchroniser before the address phase
      repeat (32) @(negedge clk);
      rq_wr = r.wr;
      rq_addr = r.addr;
      rq_data = r.data;
      rq_valid = 1'b1;
      for (n = 0; n < 1000 && rq_ready !== 1'b1; n++)
         @(negedge clk);
      @(negedge clk);
      rq_valid = 1'b0;
      for (n = 0; n < 1000 && rsp_valid !== 1'b1; n++)
         @(negedge clk);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // watchdog: whole sequence needs well under 25000 clocks
   initial begin
      #100000;
      n_errors++;
      summarize();
   end
   initial begin
      bus_if.extra_req_n = 3'h7;
      bus_if.extra_int_n = 3'h7;
      bus_if.serr_n = 1'b1;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      for (n = 0; n < 1000 && rq_ready !== 1'b1; n++)
         @(negedge clk);
      @(posedge bus_if.bus_clk);
      t0 = $time;
      @(posedge bus_if.bus_clk);
      chk(32'($time - t0), 32'h28, "bus clock period");
      $display("bus clock done");
      foreach (rows[i]) begin
         txn(rows[i]);
         chk(32'(rsp_valid), 32'h1, "response");
         chk(32'(rsp_st), 32'(rows[i].st), "status");
         if (rows[i].st == 2'h0 && !rows[i].wr)
            chk(rsp_data, rows[i].data, "read data");
         if (rows[i].st == 2'h0 && rows[i].wr) begin
            chk(wr_data, rows[i].data, "write data");
            chk(32'(wr_idx), 32'(rows[i].addr[3:2]), "write index");
         end
         $display("row %0d done", i);
      end
      ag_retry = 1'b0;
      // lanes 0 and 1 only, then the whole word read back
      rq_be = 4'hC;
      txn('{1'b1, 1'b0, 2'h0, 32'h0001_0000, 32'h1234_5678});
      rq_be = 4'h0;
      txn('{1'b0, 1'b0, 2'h0, 32'h0001_0000, 32'h0});
      chk(rsp_data, 32'hA5A5_5678, "byte lanes");
      chk(n_wstb, 32'h3, "write strobes");
      chk(n_perr, 32'h0, "parity flags");
      $display("transfers done");
      // arbitration: agent first, then master 1, then agent again
      ag_req = 1'b1;
      for (n = 0; n < 2000 && granted !== 1'b1; n++)
         @(negedge clk);
      chk(32'(bus_if.gnt_n), 32'hE, "agent grant");
      chk(32'(granted), 32'h1, "granted flag");
      bus_if.extra_req_n = 3'h6;
      ag_req = 1'b0;
      for (n = 0; n < 2000 && bus_if.gnt_n[1] !== 1'b0; n++)
         @(negedge clk);
      chk(32'(bus_if.gnt_n), 32'hD, "second grant");
      ag_req = 1'b1;
      for (n = 0; n < 2000 && bus_if.gnt_n[0] !== 1'b0; n++)
         @(negedge clk);
      chk(32'(bus_if.gnt_n), 32'hE, "rotation");
      ag_req = 1'b0;
      bus_if.extra_req_n = 3'h5;
      repeat (400) @(negedge clk);
      chk(32'(bus_if.gnt_n[2]), 32'h1, "masked master");
      $display("arbitration done");
      // second reset with the strap high
      strap = 1'b1;
      rst = 1'b1;
      repeat (4) @(negedge clk);
      chk(32'(bus_if.gnt_n), 32'hF, "grants in reset");
      chk(32'({bus_if.bus_rst_n, bus_if.br_ad_oe}), 32'h0, "bus reset");
      rst = 1'b0;
      for (n = 0; n < 2000 && bus_if.gnt_n[2] !== 1'b0; n++)
         @(negedge clk);
      chk(32'(bus_if.gnt_n), 32'hB, "third master");
      bus_if.extra_req_n = 3'h7;
      $display("strap done");
      // each interrupt line alone, then none
      for (int i = 0; i < 5; i++) begin
         pat = (i < 4) ? 4'h1 << i : 4'h0;
         ag_int = pat[0];
         bus_if.extra_int_n = ~pat[3:1];
         repeat (60) @(negedge clk);
         chk(32'(int_pend), 32'(pat), "interrupt pending");
      end
      bus_if.serr_n = 1'b0;
      repeat (10) @(negedge clk);
      chk(32'(sys_err), 32'h1, "system error");
      bus_if.serr_n = 1'b1;
      repeat (10) @(negedge clk);
      chk(32'(sys_err), 32'h0, "system error off");
      $display("interrupts done");
      summarize();
   end
endmodule
`default_nettype wire
